/* hw/pmpg_top.sv */
// Program memory partition decode, write guard and execution guard
//
// Overview of operation
// - Program counter is fifteen bits, 32K words
// - Reset fetches word zero, interrupt word four
// - Last address 1FFFh or 3FFFh by size
// - Both enables high: all flash is application
// - Boot enabled: zero to boot last address
// - Application follows boot, ends last minus 80h with storage enabled, else at last
// - Storage enabled: final 128 words are storage
// - Storage words are never executable
// - Separate write protect bit per block
// - Protected write: memory unchanged, error flag set
// - Bad fetch: violation reset, violation flag cleared
// - Unimplemented data locations read as zero
`timescale 1ns/1ps

module pmpg_top (
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Configuration straps, captured while reset is high
  input wire pmpg_pkg::pmpg_cfg_type cfg_i,
  // Program counter control from the core
  input wire logic pc_advance_i,
  input wire logic pc_load_i,
  input wire logic [6:0] pc_high_latch_i,
  input wire logic [7:0] pc_load_low_i,
  input wire logic irq_take_i,
  input wire logic exec_i,
  output logic [14:0] pc_o,
  output pmpg_pkg::pmpg_region_type pc_region_o,
  output logic exec_violation_reset_o,
  // Non-volatile write controller
  input wire pmpg_pkg::pmpg_nvm_req_type nvm_req_i,
  output logic nvm_wr_commit_o,
  output logic nvm_wr_reject_o,
  // Data memory read path
  input wire logic data_rd_i,
  input wire logic data_impl_i,
  input wire logic [7:0] data_rd_data_i,
  output logic [7:0] data_rd_data_o,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic irq_o
);

  // Last boot word for a size code, kept inside the memory
  // Each step down in the size code doubles the boot block, starting
  // from the smallest block at the largest code. A shift is cheaper
  // than a lookup table and keeps the sizes in one constant.
  function automatic logic [14:0] boot_last_of(
    input logic [2:0] size,
    input logic [14:0] last
  );
    logic [16:0] words;
    logic [16:0] top;
    words = pmpg_pkg::BOOT_MIN_WORDS << (pmpg_pkg::BOOT_SIZE_MAX - size);
    top = words - 17'h00001;
    // Oversized codes clamp to the end of memory
    if (top > {2'b00, last}) begin
      boot_last_of = last;
    end else begin
      boot_last_of = top[14:0];
    end
  endfunction

  // Region that owns a word address
  // Shared by the fetch check and the write guard, so both sides of
  // the block always agree on where one block ends and the next starts.
  // The order of the tests is the priority when blocks overlap.
  function automatic pmpg_pkg::pmpg_region_type region_of(
    input logic [14:0] a,
    input pmpg_pkg::pmpg_cfg_type c,
    input logic [14:0] last,
    input logic [14:0] saf_base,
    input logic [14:0] boot_last
  );
    region_of = pmpg_pkg::PMPG_RGN_NONE;
    if (a > last) begin
      // Beyond the implemented flash
      region_of = pmpg_pkg::PMPG_RGN_NONE;
    end else if (!c.storage_area_enable_n && a >= saf_base) begin
      // Storage area wins the top words over a large boot block
      region_of = pmpg_pkg::PMPG_RGN_SAF;
    end else if (!c.boot_block_enable_n && a <= boot_last) begin
      region_of = pmpg_pkg::PMPG_RGN_BOOT;
    end else begin
      // Everything else, or all of it with both enables high
      region_of = pmpg_pkg::PMPG_RGN_APP;
    end
  endfunction

  // Latched configuration
  pmpg_pkg::pmpg_cfg_type cfg_q;

  // Program counter state
  logic [14:0] pc_q;
  logic [14:0] pc_d;

  // Register file state
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // Registered outputs
  logic viol_rst_q;
  logic commit_q;
  logic reject_q;
  logic [7:0] data_q;

  // Capture straps during reset so they hold still while running
  // No reset branch: the straps themselves are the value after reset.
  // Straps that move while running are ignored until the next reset,
  // so the partition can never shift under running code.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cfg_q <= cfg_i;
    end
  end

  // Partition boundaries, all derived from the last address
  // These are plain combinational terms of registered straps, so the
  // long subtract and compare chains have a whole cycle to settle.
  // Limitation: only the two documented memory sizes are decoded.
  logic [14:0] last_addr;
  logic [14:0] saf_base;
  logic [14:0] boot_last;
  logic [14:0] app_first;
  logic [14:0] app_last;
  assign last_addr = cfg_q.size_16k ? pmpg_pkg::LAST_ADDR_16K :
                     pmpg_pkg::LAST_ADDR_8K;
  assign saf_base = last_addr - pmpg_pkg::SAF_SPAN_M1;
  assign boot_last = boot_last_of(cfg_q.boot_block_size,
                                  last_addr);
  // Application start and end; only the end is read back by software
  assign app_first = cfg_q.boot_block_enable_n ? 15'h0000 :
                     boot_last + 15'h0001;
  assign app_last = cfg_q.storage_area_enable_n ? last_addr :
                    last_addr - pmpg_pkg::APP_TOP_GAP;

  // Fetch decode on the current program counter
  pmpg_pkg::pmpg_region_type pc_region;
  logic exec_ok;
  logic exec_bad;
  assign pc_region = region_of(pc_q, cfg_q, last_addr, saf_base,
                               boot_last);
  // Storage words and unimplemented words cannot run
  assign exec_ok = (pc_region == pmpg_pkg::PMPG_RGN_APP) ||
                   (pc_region == pmpg_pkg::PMPG_RGN_BOOT);
  assign exec_bad = exec_i && !exec_ok;

  // Next program counter: vector first, then jump, then step
  // The violation comes first so that a bad fetch can never be
  // masked by an interrupt or a jump arriving in the same cycle.
  // A load takes its upper bits from the core's high latch.
  always_comb begin
    pc_d = pc_q;
    if (exec_bad) begin
      // A violation restarts fetching at the reset vector
      pc_d = pmpg_pkg::RESET_VECTOR;
    end else if (irq_take_i) begin
      pc_d = pmpg_pkg::IRQ_VECTOR;
    end else if (pc_load_i) begin
      pc_d = {pc_high_latch_i, pc_load_low_i};
    end else if (pc_advance_i) begin
      // Wraps within the 15-bit space
      pc_d = pc_q + 15'h0001;
    end
  end

  // Program counter register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pc_q <= pmpg_pkg::RESET_VECTOR;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Write guard: each block has its own protect bit
  // Configuration writes bypass the flash decode entirely; their
  // address space is separate and has its own protect bit.
  // Any address that no block owns is treated as protected.
  pmpg_pkg::pmpg_region_type wr_region;
  logic wr_protected;
  logic wr_take;
  logic wr_refuse;
  assign wr_region = region_of(nvm_req_i.addr, cfg_q, last_addr,
                               saf_base, boot_last);
  assign wr_protected =
    nvm_req_i.cfg_space ? cfg_q.config_write_protect :
    (wr_region == pmpg_pkg::PMPG_RGN_APP) ? cfg_q.app_write_protect :
    (wr_region == pmpg_pkg::PMPG_RGN_BOOT) ? cfg_q.boot_write_protect :
    (wr_region == pmpg_pkg::PMPG_RGN_SAF) ?
      cfg_q.storage_write_protect :
    1'b1;
  // Unimplemented flash words are refused like protected ones
  assign wr_take = nvm_req_i.valid && !wr_protected;
  assign wr_refuse = nvm_req_i.valid && wr_protected;

  // Commit or reject pulse, one cycle after the request
  // Exactly one of the two answers follows every valid request, and
  // the controller must not touch memory unless commit is seen.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      commit_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      commit_q <= wr_take;
      reject_q <= wr_refuse;
    end
  end

  // Violation reset pulse, suppressed when disabled by software
  // The pulse is registered so the reset it drives is glitch free.
  // It resets the core only; this block must keep its sticky state
  // so software can see why the core restarted.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      viol_rst_q <= 1'b0;
    end else begin
      viol_rst_q <= exec_bad && ctrl_q[pmpg_pkg::CT_VIOL_RST_EN];
    end
  end

  // Data reads of unimplemented locations return zero
  // The result holds until the next read, so a slow consumer may
  // sample it any time before issuing another strobe.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      data_q <= 8'h00;
    end else if (data_rd_i) begin
      data_q <= data_impl_i ? data_rd_data_i : 8'h00;
    end
  end

  // Register write decode
  logic wr_status;
  logic wr_mask;
  logic wr_ctrl;
  assign wr_status = reg_wr_i && (reg_addr_i == pmpg_pkg::REG_STATUS);
  assign wr_mask = reg_wr_i && (reg_addr_i == pmpg_pkg::REG_MASK);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == pmpg_pkg::REG_CTRL);

  // Hardware events for the sticky status bits
  logic [1:0] events;
  assign events = {exec_bad, wr_refuse};

  // Status: write one to clear, a new event in the same cycle wins
  // Letting the set win means an event that lands on the clear is
  // never lost; software sees it on the next read instead.
  // Writing zero to a bit leaves it as it was.
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~reg_wdata_i[1:0];
    end
    status_d = status_d | events;
  end

  // Control: the violation flag is set by software, cleared by hardware
  // Software arms the flag after reading it; a cleared flag then
  // tells it that a violation reset has happened since.
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d[pmpg_pkg::CT_VIOL_RST_EN] =
        reg_wdata_i[pmpg_pkg::CT_VIOL_RST_EN];
      // Writing zero leaves the flag alone
      ctrl_d[pmpg_pkg::CT_VIOL_FLAG] = ctrl_q[pmpg_pkg::CT_VIOL_FLAG] |
        reg_wdata_i[pmpg_pkg::CT_VIOL_FLAG];
    end
    // The hardware clear beats a software set in the same cycle
    if (exec_bad) begin
      ctrl_d[pmpg_pkg::CT_VIOL_FLAG] = 1'b0;
    end
  end

  // Software-visible registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      status_q <= pmpg_pkg::STATUS_RST;
      mask_q <= pmpg_pkg::MASK_RST;
      ctrl_q <= pmpg_pkg::CTRL_RST;
    end else begin
      status_q <= status_d;
      ctrl_q <= ctrl_d;
      if (wr_mask) begin
        mask_q <= reg_wdata_i[1:0];
      end
    end
  end

  // Read selection; unmapped offsets read zero
  // The chain is only as deep as the register map; it is driven by
  // the address alone, so the read strobe only gates the register.
  // Boundary registers let software check the partition it booted.
  logic [15:0] rd_mux;
  assign rd_mux =
    (reg_addr_i == pmpg_pkg::REG_CFG) ? {6'h00, cfg_q} :
    (reg_addr_i == pmpg_pkg::REG_BOOT_LAST) ? {1'b0, boot_last} :
    (reg_addr_i == pmpg_pkg::REG_APP_LAST) ? {1'b0, app_last} :
    (reg_addr_i == pmpg_pkg::REG_STATUS) ? {14'h0000, status_q} :
    (reg_addr_i == pmpg_pkg::REG_MASK) ? {14'h0000, mask_q} :
    (reg_addr_i == pmpg_pkg::REG_CTRL) ? {14'h0000, ctrl_q} :
    (reg_addr_i == pmpg_pkg::REG_PC) ? {1'b0, pc_q} :
    16'h0000;

  // Read data is valid only in the cycle after the strobe
  assign rdata_d = reg_rd_i ? rd_mux : 16'h0000;

  // Read data register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Output drive
  assign pc_o = pc_q;
  assign pc_region_o = pc_region;
  assign exec_violation_reset_o = viol_rst_q;
  assign nvm_wr_commit_o = commit_q;
  assign nvm_wr_reject_o = reject_q;
  assign data_rd_data_o = data_q;
  assign reg_rdata_o = rdata_q;
  // Level interrupt while any unmasked status bit stands
  assign irq_o = |(status_q & mask_q);

  // The application start is exported only through software readback
  // of boot_last; app_first documents the lower bound for the decoder.
  logic app_first_unused;
  assign app_first_unused = ^app_first;

endmodule

/* hw/pmpg_pkg.sv */
// Constants and types for the program memory partition guard
package pmpg_pkg;

  // Program counter and word widths
  localparam int PC_W = 15;
  localparam int WORD_W = 14;
  localparam int REG_W = 16;

  // Fixed vectors and memory size limits
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam logic [14:0] LAST_ADDR_8K = 15'h1fff;
  localparam logic [14:0] LAST_ADDR_16K = 15'h3fff;

  // Storage area spans the last 128 words
  localparam logic [14:0] SAF_SPAN_M1 = 15'h007f;
  localparam logic [14:0] APP_TOP_GAP = 15'h0080;

  // Smallest boot block, in words, for size code 7
  localparam logic [16:0] BOOT_MIN_WORDS = 17'h00200;
  localparam logic [2:0] BOOT_SIZE_MAX = 3'h7;

  // Register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_BOOT_LAST = 8'h04;
  localparam logic [7:0] REG_APP_LAST = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_PC = 8'h18;

  // Status and mask bit positions
  localparam int ST_WR_ERR = 0;
  localparam int ST_EXEC_VIOL = 1;
  localparam int ST_W = 2;

  // Control bit positions
  localparam int CT_VIOL_FLAG = 0;
  localparam int CT_VIOL_RST_EN = 1;
  localparam int CT_W = 2;

  // Values after reset
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] CTRL_RST = 2'h3;

  // Region of a program word address
  typedef enum logic [1:0] {
    PMPG_RGN_NONE = 2'b00,
    PMPG_RGN_APP = 2'b01,
    PMPG_RGN_BOOT = 2'b10,
    PMPG_RGN_SAF = 2'b11
  } pmpg_region_type;

  // Configuration bits as latched at reset
  typedef struct packed {
    logic size_16k;
    logic config_write_protect;
    logic storage_write_protect;
    logic boot_write_protect;
    logic app_write_protect;
    logic [2:0] boot_block_size;
    logic storage_area_enable_n;
    logic boot_block_enable_n;
  } pmpg_cfg_type;

  // Write request from the non-volatile controller
  typedef struct packed {
    logic valid;
    logic cfg_space;
    logic [14:0] addr;
  } pmpg_nvm_req_type;

endpackage

/* test/pmpg_monitor.sv */
// Concurrent checks on the partition guard ports
`timescale 1ns/1ps
module pmpg_monitor (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire pmpg_pkg::pmpg_cfg_type cfg_i,
  input wire logic irq_take_i,
  input wire logic exec_i,
  input wire logic [14:0] pc_o,
  input wire pmpg_pkg::pmpg_region_type pc_region_o,
  input wire logic exec_violation_reset_o,
  input wire pmpg_pkg::pmpg_nvm_req_type nvm_req_i,
  input wire logic nvm_wr_commit_o,
  input wire logic nvm_wr_reject_o
);
  // Last address from the size strap; straps stay steady while running
  wire [14:0] last_w = cfg_i.size_16k ? 15'h3fff : 15'h1fff;
  // Region decodes of the current pc
  wire saf_w = pc_region_o == pmpg_pkg::PMPG_RGN_SAF;
  wire none_w = pc_region_o == pmpg_pkg::PMPG_RGN_NONE;
  wire app_w = pc_region_o == pmpg_pkg::PMPG_RGN_APP;
  // A fetch that may not execute
  wire bad_w = exec_i && (saf_w || none_w);
  wire both_off_w = cfg_i.boot_block_enable_n && cfg_i.storage_area_enable_n;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Execution guard steps: bad fetch, then pulse with pc back at zero
  sequence bad_fetch;
    bad_w;
  endsequence
  sequence vec_reset;
    exec_violation_reset_o && pc_o == 15'h0000;
  endsequence
  AST_VIOL_RESET: assert property (bad_fetch |=> vec_reset)
    else $error("no violation reset after bad fetch");
  AST_VIOL_CAUSE: assert property (exec_violation_reset_o |-> $past(bad_w))
    else $error("violation reset without bad fetch");
  AST_VIOL_ONCE: assert property (vec_reset |=> !exec_violation_reset_o [*2])
    else $error("violation reset longer than one cycle");
  AST_NVM_ANSWER: assert property
    (nvm_req_i.valid |=> nvm_wr_commit_o != nvm_wr_reject_o)
    else $error("write request without one answer");
  AST_NVM_CAUSE: assert property
    (nvm_wr_commit_o || nvm_wr_reject_o |-> $past(nvm_req_i.valid))
    else $error("write answer without request");
  AST_IRQ_VEC: assert property (irq_take_i && !bad_w |=> pc_o == 15'h0004)
    else $error("interrupt did not vector to four");
  AST_PC_START: assert property ($fell(reset_i) |-> pc_o == 15'h0000)
    else $error("pc not zero after reset");
  AST_SAF_TOP: assert property
    (saf_w |-> (pc_o | 15'h007f) == last_w && !cfg_i.storage_area_enable_n)
    else $error("storage region outside final words");
  AST_ABOVE_LAST: assert property (pc_o > last_w |-> none_w)
    else $error("region given above last address");
  AST_ALL_APP: assert property (both_off_w && pc_o <= last_w |-> app_w)
    else $error("flash not all application");
endmodule

bind pmpg_top pmpg_monitor u_mon (.core_clk_i, .reset_i, .cfg_i,
  .irq_take_i, .exec_i, .pc_o, .pc_region_o, .exec_violation_reset_o,
  .nvm_req_i, .nvm_wr_commit_o, .nvm_wr_reject_o);

/* test/pmpg_nvm_ctrl_model.sv */
// Behavioural write controller that issues one-cycle write requests
`timescale 1ns/1ps
module pmpg_nvm_ctrl_model (
  input wire logic core_clk_i,
  input wire logic go_i,
  input wire logic cfg_space_i,
  input wire logic [14:0] addr_i,
  output pmpg_pkg::pmpg_nvm_req_type req_o
);
  initial req_o = '0;
  // Idle address toggles so a stale value can never pass for a request
  always @(posedge core_clk_i) begin
    if (go_i) begin
      req_o <= {1'b1, cfg_space_i, addr_i};
    end else begin
      req_o <= {1'b0, ~req_o.cfg_space, ~req_o.addr};
    end
  end
endmodule

/* test/pmpg_tb_top.sv */
// Directed bench for the partition guard
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module pmpg_tb_top;
  logic core_clk_i = 0, reset_i = 1, pc_advance_i = 0, pc_load_i = 0;
  logic irq_take_i = 0, exec_i = 0, data_rd_i = 0, data_impl_i = 0;
  logic reg_wr_i = 0, reg_rd_i = 0, go = 0, go_cfg = 0, irq_o;
  logic [6:0] pc_high_latch_i = '0;
  logic [7:0] pc_load_low_i = '0, data_rd_data_i = '0, reg_addr_i = '0;
  logic [7:0] data_rd_data_o;
  logic [15:0] reg_wdata_i = '0, reg_rdata_o;
  logic [14:0] go_addr = '0, pc_o;
  logic exec_violation_reset_o, nvm_wr_commit_o, nvm_wr_reject_o;
  pmpg_pkg::pmpg_cfg_type cfg_i = 10'h03c;
  pmpg_pkg::pmpg_nvm_req_type nvm_req_i;
  pmpg_pkg::pmpg_region_type pc_region_o;
  int err_total = 0, comparisons = 0;
  // Probe addresses and expected region codes for the first strap set
  logic [14:0] pa [8] = '{15'h0000, 15'h01ff, 15'h0200, 15'h1f7f,
    15'h1f80, 15'h1fff, 15'h2000, 15'h7fff};
  logic [1:0] rg [8] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h3, 2'h0, 2'h0};
  always #4 core_clk_i = ~core_clk_i;
  pmpg_top DUT (.core_clk_i, .reset_i, .cfg_i, .pc_advance_i, .pc_load_i,
    .pc_high_latch_i, .pc_load_low_i, .irq_take_i, .exec_i, .pc_o,
    .pc_region_o, .exec_violation_reset_o, .nvm_req_i, .nvm_wr_commit_o,
    .nvm_wr_reject_o, .data_rd_i, .data_impl_i, .data_rd_data_i,
    .data_rd_data_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .irq_o);
  pmpg_nvm_ctrl_model u_nvm (.core_clk_i, .go_i(go), .cfg_space_i(go_cfg),
    .addr_i(go_addr), .req_o(nvm_req_i));
  // Straps must be valid at the last reset edge
  task automatic do_reset(input pmpg_pkg::pmpg_cfg_type c);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    cfg_i <= c;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    #1;
  endtask
  // Register read: data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] ex, string nm);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(nm, ex, reg_rdata_o)
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  // Load pc from the high latch and low byte, then check its region
  task automatic ld(input logic [14:0] a, input logic [1:0] r);
    @(posedge core_clk_i);
    pc_load_i <= 1'b1;
    pc_high_latch_i <= a[14:8];
    pc_load_low_i <= a[7:0];
    @(posedge core_clk_i);
    pc_load_i <= 1'b0;
    #1 `CHK("pc", a, pc_o)
    `CHK("region", r, pc_region_o)
  endtask
  // One-cycle core strobe: bit2 execute, bit1 interrupt, bit0 advance
  task automatic step(input logic [2:0] s);
    @(posedge core_clk_i);
    {exec_i, irq_take_i, pc_advance_i} <= s;
    @(posedge core_clk_i);
    {exec_i, irq_take_i, pc_advance_i} <= 3'h0;
    #1;
  endtask
  // Write request through the model; answer lands one cycle after it
  task automatic nvm(input logic [14:0] a, input logic c, input logic ok);
    @(posedge core_clk_i);
    go <= 1'b1;
    go_addr <= a;
    go_cfg <= c;
    @(posedge core_clk_i);
    go <= 1'b0;
    @(posedge core_clk_i);
    #1 `CHK("commit", ok, nvm_wr_commit_o)
    `CHK("reject", ~ok, nvm_wr_reject_o)
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    print_verdict();
  end
  initial begin
    do_reset(10'h03c);
    `CHK("pc", 15'h0000, pc_o)
    rd(pmpg_pkg::REG_CTRL, 16'h0003, "ctrl");
    rd(pmpg_pkg::REG_CFG, 16'h003c, "cfg");
    rd(pmpg_pkg::REG_BOOT_LAST, 16'h01ff, "boot_last");
    rd(pmpg_pkg::REG_APP_LAST, 16'h1f7f, "app_last");
    rd(8'h40, 16'h0000, "unmapped");
    for (int i = 0; i < 8; i++) ld(pa[i], rg[i]);
    step(3'h2);
    `CHK("pc", 15'h0004, pc_o)
    step(3'h1);
    `CHK("pc", 15'h0005, pc_o)
    wr(pmpg_pkg::REG_MASK, 16'h0003);
    nvm(15'h0300, 1'b0, 1'b0);
    `CHK("irq", 1'b1, irq_o)
    rd(pmpg_pkg::REG_STATUS, 16'h0001, "status");
    nvm(15'h0100, 1'b0, 1'b1);
    nvm(15'h1f90, 1'b0, 1'b1);
    nvm(15'h2000, 1'b0, 1'b0);
    nvm(15'h0000, 1'b1, 1'b1);
    wr(pmpg_pkg::REG_STATUS, 16'h0001);
    `CHK("irq", 1'b0, irq_o)
    ld(15'h1f80, 2'h3);
    step(3'h4);
    `CHK("viol", 1'b1, exec_violation_reset_o)
    `CHK("pc", 15'h0000, pc_o)
    rd(pmpg_pkg::REG_STATUS, 16'h0002, "status");
    rd(pmpg_pkg::REG_CTRL, 16'h0002, "ctrl");
    wr(pmpg_pkg::REG_CTRL, 16'h0003);
    rd(pmpg_pkg::REG_CTRL, 16'h0003, "ctrl");
    // Data reads: unimplemented location gives zero
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_i);
      data_rd_i <= 1'b1;
      data_impl_i <= i[0];
      data_rd_data_i <= 8'ha5;
      @(posedge core_clk_i);
      data_rd_i <= 1'b0;
      #1 `CHK("data", i ? 8'ha5 : 8'h00, data_rd_data_o)
    end
    do_reset(10'h21f);
    rd(pmpg_pkg::REG_APP_LAST, 16'h3fff, "app_last");
    ld(15'h0000, 2'h1);
    ld(15'h3fff, 2'h1);
    step(3'h4);
    `CHK("viol", 1'b0, exec_violation_reset_o)
    nvm(15'h3fff, 1'b0, 1'b1);
    print_verdict();
  end
endmodule
